/* logic/tism_cfg.svh */
// Register map, field positions and reset values of the touch interrupt,
// sleep selection and multi-touch blocking block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TISM_CFG_SVH
`define TISM_CFG_SVH

// Register offsets on the device register port
`define TISM_ADDR_TOUCH_IRQ_EN    8'h27
`define TISM_ADDR_GPIO_IRQ_EN     8'h28
`define TISM_ADDR_SLEEP_SELECT    8'h29
`define TISM_ADDR_MULTI_CONFIG    8'h2A

// Reset values
`define TISM_RST_TOUCH_IRQ_EN     8'hFF
`define TISM_RST_GPIO_IRQ_EN      8'h00
`define TISM_RST_SLEEP_SELECT     8'h00
`define TISM_RST_MULTI_CONFIG     8'h82

// Field positions
`define TISM_BIT_GROUP            7
`define TISM_BIT_BLOCK_EN         7
`define TISM_BTN_LIMIT_HI         3
`define TISM_BTN_LIMIT_LO         2
`define TISM_GRP_LIMIT_HI         1
`define TISM_GRP_LIMIT_LO         0

// Writable bits of the multi-touch configuration; the rest read as zero
`define TISM_MULTI_CONFIG_MASK    8'h8F

// Unmapped offsets read as this value
`define TISM_UNMAPPED_READ        8'h00

`endif

/* logic/tism_pkg.sv */
// Types shared by the touch interrupt, sleep and multi-touch block.
// Assumes tism_cfg.svh is reachable on the include path.
`include "tism_cfg.svh"

package tism_pkg;

    // One access on the device register port
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } tism_reg_req_t;

    // Grouped-sensor status flags (slide up, slide down, tap, press and hold)
    typedef struct packed {
        logic up;
        logic down;
        logic tap;
        logic pressHoldFlag;
    } tism_grp_evt_t;

    // Multiple-touch event flags
    typedef struct packed {
        logic button;
        logic group;
    } tism_mt_flags_t;

endpackage

/* logic/tism_pop7.sv */
// Population count of a seven-bit sensor vector.
// Assumes a purely combinational use inside the same clock domain.
`timescale 1ns/1ps

module tism_pop7 (
    // Sensor vector
    input  wire logic [6:0] bits,
    // Number of set bits
    output logic      [2:0] count
);

    // Adder tree flattened into a loop; seven inputs never exceed 3 bits
    always_comb begin
        count = 3'h0;
        for (int i = 0; i < 7; i++) begin
            count = count + {2'h0, bits[i]};
        end
    end

endmodule // tism_pop7

/* logic/tism_top.sv */
// Interrupt gating, Sleep sample selection and multiple-touch blocking
// for a capacitive touch controller.
// Assumes the serial management bus engine presents register accesses on
// the register port in the same clock domain, and that sensing and status
// logic feed touch and status levels synchronous to that clock.
`timescale 1ns/1ps
`include "tism_cfg.svh"

// Notes on behaviour
// - Group enable gates slide, tap, hold interrupts
// - Low bits gate button touch interrupts
// - Cleared enable keeps its source silent
// - Second enable register gates GPIO status interrupts
// - Sleep register picks sensors sampled in Sleep
// - Group sleep bit samples enabled grouped sensors
// - Button sleep bit samples that button
// - Sleep channels newly added while in Sleep get slower conversion
// - Top config bit enables multi-touch blocking
// - Accept up to limit, hold until release
// - Button limit field, flag when exceeded
// - Group limit field, flag when exceeded
module tism_top (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    // Register port from the management bus engine
    input  wire tism_pkg::tism_reg_req_t regReq,
    output logic                  [7:0]  regRdData,
    // Status flags from the status registers
    input  wire logic             [6:0]  buttonStatus,
    input  wire tism_pkg::tism_grp_evt_t groupStatus,
    input  wire logic             [7:0]  gpioStatus,
    // Power state and sensing front end
    input  wire logic                    sleepState,
    input  wire logic             [6:0]  groupSensorEnable,
    input  wire logic             [6:0]  buttonTouchRaw,
    input  wire logic             [6:0]  groupTouchRaw,
    input  wire logic                    conversionDone,
    // Interrupt and sensing control
    output logic                         irqOut,
    output logic                  [6:0]  buttonSampleEn,
    output logic                  [6:0]  groupSampleEn,
    output logic                  [7:0]  firstConvPending,
    // Touches passed on after blocking, and multi-touch flags
    output logic                  [6:0]  buttonTouchValid,
    output logic                  [6:0]  groupTouchValid,
    output tism_pkg::tism_mt_flags_t     multiFlags
);
    import tism_pkg::*;

    logic [7:0] touchIrqEnable;
    logic [7:0] gpioIrqEnable;
    logic [7:0] sleepSampleSelect;
    logic [7:0] multiTouchConfig;

    logic       wrTouchEn;
    logic       wrGpioEn;
    logic       wrSleep;
    logic       wrMulti;
    logic [7:0] addedChannels;

    logic       groupPending;
    logic       next_irq;
    logic       multiBlockEnable;
    logic [2:0] buttonTouchLimit;
    logic [2:0] groupTouchLimit;
    logic [6:0] effBtn;
    logic [6:0] effGrp;
    logic [6:0] keepBtn;
    logic [6:0] keepGrp;
    logic [2:0] cntBtn;
    logic [2:0] cntGrp;
    logic [2:0] cntKeepBtn;
    logic [2:0] cntKeepGrp;
    logic [6:0] next_buttonValid;
    logic [6:0] next_groupValid;
    logic [6:0] next_groupSample;

    // Address decode of writes
    assign wrTouchEn = regReq.wr && (regReq.addr == `TISM_ADDR_TOUCH_IRQ_EN);
    assign wrGpioEn  = regReq.wr && (regReq.addr == `TISM_ADDR_GPIO_IRQ_EN);
    assign wrSleep   = regReq.wr && (regReq.addr == `TISM_ADDR_SLEEP_SELECT);
    assign wrMulti   = regReq.wr && (regReq.addr == `TISM_ADDR_MULTI_CONFIG);

    // First interrupt enable register: group bit and seven button bits
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            touchIrqEnable <= `TISM_RST_TOUCH_IRQ_EN;
        end else if (wrTouchEn) begin
            touchIrqEnable <= regReq.wdata;
        end
    end

    // Second interrupt enable register: GPIO status bits, off after reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gpioIrqEnable <= `TISM_RST_GPIO_IRQ_EN;
        end else if (wrGpioEn) begin
            gpioIrqEnable <= regReq.wdata;
        end
    end

    // Sleep sample selection, nothing sampled in Sleep after reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sleepSampleSelect <= `TISM_RST_SLEEP_SELECT;
        end else if (wrSleep) begin
            sleepSampleSelect <= regReq.wdata;
        end
    end

    // Multi-touch configuration; unused bits are not stored so they read zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            multiTouchConfig <= `TISM_RST_MULTI_CONFIG;
        end else if (wrMulti) begin
            multiTouchConfig <= regReq.wdata & `TISM_MULTI_CONFIG_MASK;
        end
    end

    // Registered read data; unmapped offsets answer zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regReq.rd) begin
            case (regReq.addr)
                `TISM_ADDR_TOUCH_IRQ_EN: regRdData <= touchIrqEnable;
                `TISM_ADDR_GPIO_IRQ_EN:  regRdData <= gpioIrqEnable;
                `TISM_ADDR_SLEEP_SELECT: regRdData <= sleepSampleSelect;
                `TISM_ADDR_MULTI_CONFIG: regRdData <= multiTouchConfig;
                default:                 regRdData <= `TISM_UNMAPPED_READ;
            endcase
        end
    end

    // Interrupt: each pending source only counts with its enable bit set
    assign groupPending = groupStatus.up | groupStatus.down | groupStatus.tap
                        | groupStatus.pressHoldFlag;
    assign next_irq = (groupPending && touchIrqEnable[`TISM_BIT_GROUP])
                    | (|(buttonStatus & touchIrqEnable[6:0]))
                    | (|(gpioStatus & gpioIrqEnable));

    // Registered so the pin never glitches while flags and enables settle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= next_irq;
        end
    end

    // Sampling: awake, all buttons and enabled grouped sensors run; in Sleep
    // only the selected ones, grouped sensors still limited by their enable
    assign next_groupSample = sleepSampleSelect[`TISM_BIT_GROUP] ? groupSensorEnable : 7'h00;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            buttonSampleEn <= 7'h7F;
            groupSampleEn  <= 7'h00;
        end else if (sleepState) begin
            buttonSampleEn <= sleepSampleSelect[6:0];
            groupSampleEn  <= next_groupSample;
        end else begin
            buttonSampleEn <= 7'h7F;
            groupSampleEn  <= groupSensorEnable;
        end
    end

    // Channels switched on in Sleep take a longer first conversion; the mark
    // clears on the next conversion, but a new addition in that cycle wins
    assign addedChannels = regReq.wdata & ~sleepSampleSelect;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            firstConvPending <= 8'h00;
        end else if (wrSleep && sleepState) begin
            firstConvPending <= (conversionDone ? 8'h00 : firstConvPending)
                              | addedChannels;
        end else if (conversionDone) begin
            firstConvPending <= 8'h00;
        end
    end

    // Limit decode
    assign multiBlockEnable = multiTouchConfig[`TISM_BIT_BLOCK_EN];
    assign buttonTouchLimit =
        {1'b0, multiTouchConfig[`TISM_BTN_LIMIT_HI:`TISM_BTN_LIMIT_LO]} + 3'h1;
    always_comb begin
        case (multiTouchConfig[`TISM_GRP_LIMIT_HI:`TISM_GRP_LIMIT_LO])
            2'b00:   groupTouchLimit = 3'h2;
            2'b01:   groupTouchLimit = 3'h3;
            2'b10:   groupTouchLimit = 3'h4;
            default: groupTouchLimit = 3'h1;
        endcase
    end

    // Unsampled sensors cannot report a touch
    assign effBtn  = buttonTouchRaw & buttonSampleEn;
    assign effGrp  = groupTouchRaw & groupSampleEn;
    assign keepBtn = buttonTouchValid & effBtn;
    assign keepGrp = groupTouchValid & effGrp;

    tism_pop7 u_popBtn     (.bits(effBtn),  .count(cntBtn));
    tism_pop7 u_popGrp     (.bits(effGrp),  .count(cntGrp));
    tism_pop7 u_popKeepBtn (.bits(keepBtn), .count(cntKeepBtn));
    tism_pop7 u_popKeepGrp (.bits(keepGrp), .count(cntKeepGrp));

    // Held touches stay; new ones fill free slots, lowest sensor first
    function automatic logic [6:0] tism_accept(input logic [6:0] eff,
                                               input logic [6:0] keep,
                                               input logic [2:0] keepCnt,
                                               input logic [2:0] limit);
        logic [6:0] acc;
        logic [2:0] slot;
        acc  = keep;
        slot = keepCnt;
        for (int i = 0; i < 7; i++) begin
            if (eff[i] && !keep[i] && (slot < limit)) begin
                acc[i] = 1'b1;
                slot   = slot + 3'h1;
            end
        end
        return acc;
    endfunction

    // Without blocking every sampled touch passes straight on
    assign next_buttonValid = multiBlockEnable ?
        tism_accept(effBtn, keepBtn, cntKeepBtn, buttonTouchLimit) : effBtn;
    assign next_groupValid = multiBlockEnable ?
        tism_accept(effGrp, keepGrp, cntKeepGrp, groupTouchLimit) : effGrp;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            buttonTouchValid <= 7'h00;
            groupTouchValid  <= 7'h00;
        end else begin
            buttonTouchValid <= next_buttonValid;
            groupTouchValid  <= next_groupValid;
        end
    end

    // Multi-touch event flags follow the sampled touch count, not the blocked one
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            multiFlags <= '0;
        end else begin
            multiFlags.button <= (cntBtn > buttonTouchLimit);
            multiFlags.group  <= (cntGrp > groupTouchLimit);
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence addDuringSleep;
        wrSleep && sleepState && (addedChannels != 8'h00);
    endsequence

    sequence groupRaised;
        groupPending && touchIrqEnable[`TISM_BIT_GROUP];
    endsequence

    chk_irq_group_gate: assert property (groupRaised |=> irqOut)
        else $error("group event enabled but interrupt low");

    chk_irq_button_gate: assert property (
        (|(buttonStatus & touchIrqEnable[6:0])) |=> irqOut)
        else $error("enabled button status did not raise interrupt");

    chk_irq_masked_quiet: assert property (
        !((groupPending && touchIrqEnable[`TISM_BIT_GROUP])
          || (|(buttonStatus & touchIrqEnable[6:0]))
          || (|(gpioStatus & gpioIrqEnable))) |=> !irqOut)
        else $error("interrupt raised with no enabled source");

    chk_irq_gpio_gate: assert property (
        (|(gpioStatus & gpioIrqEnable)) |=> irqOut)
        else $error("enabled GPIO status did not raise interrupt");

    chk_sleep_group_sel: assert property (
        sleepState |=> groupSampleEn == ($past(sleepSampleSelect[`TISM_BIT_GROUP]) ?
                                         $past(groupSensorEnable) : 7'h00))
        else $error("grouped sampling in Sleep not per selection");

    chk_sleep_button_sel: assert property (
        sleepState |=> buttonSampleEn == $past(sleepSampleSelect[6:0]))
        else $error("button sampling in Sleep not per selection");

    chk_first_conv_mark: assert property (
        addDuringSleep |=> ((firstConvPending & $past(addedChannels)) == $past(addedChannels)))
        else $error("newly added Sleep channel not marked");

    chk_block_off_pass: assert property (
        !multiBlockEnable |=> buttonTouchValid == $past(effBtn))
        else $error("touches altered with blocking disabled");

    chk_button_limit_kept: assert property (
        multiBlockEnable |=> $countones(buttonTouchValid) <= $past(buttonTouchLimit))
        else $error("more buttons passed than the limit");

    chk_hold_until_release: assert property (
        (multiBlockEnable && effBtn[0] && buttonTouchValid[0]) |=> buttonTouchValid[0])
        else $error("accepted touch dropped while still held");

    chk_button_mt_flag: assert property (
        (cntBtn > buttonTouchLimit) |=> multiFlags.button)
        else $error("button multi-touch event not flagged");

    chk_group_mt_flag: assert property (
        (cntGrp > groupTouchLimit) |=> multiFlags.group ##0 (groupTouchLimit != 3'h0))
        else $error("group multi-touch event not flagged");

endmodule // tism_top

/* bench/tism_host_model.sv */
// Host side of the register port: issues one-cycle write and read strobes.
// Assumes the device takes a request on the rising edge that sees wr or rd.
`timescale 1ns/1ps
`include "tism_cfg.svh"

module tism_host_model (
    // Clock
    input  wire logic                    clock,
    // Register port toward the device
    output tism_pkg::tism_reg_req_t      regReq,
    input  wire logic             [7:0]  regRdData
);
    import tism_pkg::*;

    // Sleep selection last written, and channels it newly switched on
    logic [7:0] sleepSel;
    logic [7:0] recalMask;

    initial begin
        regReq    = '0;
        sleepSel  = 8'h00;
        recalMask = 8'h00;
    end

    // One write; address and data are scrambled once released so stale
    // values are never mistaken for a live request
    task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        #1;
        regReq.addr  = addr;
        regReq.wdata = data;
        regReq.wr    = 1'b1;
        @(posedge clock);
        #1;
        regReq.wr    = 1'b0;
        regReq.addr  = ~addr;
        regReq.wdata = ~data;
        // Newly activated Sleep channels are queued for a forced recalibration
        if (addr === `TISM_ADDR_SLEEP_SELECT) begin
            recalMask = data & ~sleepSel;
            sleepSel  = data;
        end
    endtask

    // One read; data is taken an edge after the strobe, it holds until next read
    task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        #1;
        regReq.addr = addr;
        regReq.rd   = 1'b1;
        @(posedge clock);
        #1;
        regReq.rd   = 1'b0;
        regReq.addr = ~addr;
        @(posedge clock);
        #1;
        data = regRdData;
    endtask
endmodule // tism_host_model

/* bench/touch_irq_sleep_multitouch_tb.sv */
// Self-checking bench for the interrupt gating, Sleep selection and blocking.
// Assumes the host model drives the register port; other inputs come from here.
`timescale 1ns/1ps
`include "tism_cfg.svh"

module touch_irq_sleep_multitouch_tb;
    import tism_pkg::*;

    logic           clock;
    logic           sysRst;
    tism_reg_req_t  regReq;
    logic [7:0]     regRdData;
    logic [6:0]     buttonStatus;
    tism_grp_evt_t  groupStatus;
    logic [7:0]     gpioStatus;
    logic           sleepState;
    logic [6:0]     groupSensorEnable;
    logic [6:0]     buttonTouchRaw;
    logic [6:0]     groupTouchRaw;
    logic           conversionDone;
    logic           irqOut;
    logic [6:0]     buttonSampleEn;
    logic [6:0]     groupSampleEn;
    logic [7:0]     firstConvPending;
    logic [6:0]     buttonTouchValid;
    logic [6:0]     groupTouchValid;
    tism_mt_flags_t multiFlags;
    int             badCount;
    int             samplesChecked;
    logic [6:0]     expMask;
    int             grpLimit [4] = '{2, 3, 4, 1};

    tism_top i_tism_top (
        .clock(clock), .sys_rst(sysRst), .regReq(regReq), .regRdData(regRdData),
        .buttonStatus(buttonStatus), .groupStatus(groupStatus), .gpioStatus(gpioStatus),
        .sleepState(sleepState), .groupSensorEnable(groupSensorEnable),
        .buttonTouchRaw(buttonTouchRaw), .groupTouchRaw(groupTouchRaw),
        .conversionDone(conversionDone), .irqOut(irqOut), .buttonSampleEn(buttonSampleEn),
        .groupSampleEn(groupSampleEn), .firstConvPending(firstConvPending),
        .buttonTouchValid(buttonTouchValid), .groupTouchValid(groupTouchValid),
        .multiFlags(multiFlags));

    tism_host_model i_tism_host_model (
        .clock(clock), .regReq(regReq), .regRdData(regRdData));

    // Free-running 25 MHz clock
    always #20 clock = ~clock;

    // Advance n edges and settle just past the last one
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chkVal(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            badCount++;
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        chkVal({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_tism_host_model.wrReg(addr, data);
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        i_tism_host_model.rdReg(addr, data);
        chkVal(data, exp);
    endtask

    // Single exit point of the run
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the roughly 225 cycles the tests need
    initial begin
        #(40 * 5000);
        badCount++;
        summarize();
    end

    initial begin
        clock = 1'b0; sysRst = 1'b1; buttonStatus = 7'h00; groupStatus = '0;
        gpioStatus = 8'h00; sleepState = 1'b0; groupSensorEnable = 7'h55;
        buttonTouchRaw = 7'h00; groupTouchRaw = 7'h00; conversionDone = 1'b0;
        badCount = 0; samplesChecked = 0;
        repeat (4) @(posedge clock);
        #1;
        sysRst = 1'b0;
        // Reset values, unmapped read, unstored config bits
        rdChk(`TISM_ADDR_TOUCH_IRQ_EN, 8'hFF);
        rdChk(`TISM_ADDR_GPIO_IRQ_EN, 8'h00);
        rdChk(`TISM_ADDR_SLEEP_SELECT, 8'h00);
        rdChk(`TISM_ADDR_MULTI_CONFIG, 8'h82);
        rdChk(8'h2B, 8'h00);
        wr(`TISM_ADDR_MULTI_CONFIG, 8'hFF);
        rdChk(`TISM_ADDR_MULTI_CONFIG, 8'h8F);
        wr(`TISM_ADDR_MULTI_CONFIG, 8'h82);
        // Each button source raises the interrupt, then is masked
        for (int i = 0; i < 7; i++) begin
            buttonStatus = 7'(1 << i);
            step(2);
            chkBit(irqOut, 1'b1);
            wr(`TISM_ADDR_TOUCH_IRQ_EN, 8'hFF ^ 8'(1 << i));
            step(1);
            chkBit(irqOut, 1'b0);
            wr(`TISM_ADDR_TOUCH_IRQ_EN, 8'hFF);
            buttonStatus = 7'h00;
        end
        // Each grouped flag under the group enable
        for (int j = 0; j < 4; j++) begin
            groupStatus = 4'(1 << j);
            step(2);
            chkBit(irqOut, 1'b1);
            wr(`TISM_ADDR_TOUCH_IRQ_EN, 8'h7F);
            step(1);
            chkBit(irqOut, 1'b0);
            wr(`TISM_ADDR_TOUCH_IRQ_EN, 8'hFF);
            groupStatus = '0;
        end
        // GPIO flags stay silent until enabled one at a time
        gpioStatus = 8'hFF;
        step(2);
        chkBit(irqOut, 1'b0);
        for (int k = 0; k < 8; k++) begin
            wr(`TISM_ADDR_GPIO_IRQ_EN, 8'(1 << k));
            step(1);
            chkBit(irqOut, 1'b1);
        end
        wr(`TISM_ADDR_GPIO_IRQ_EN, 8'h00);
        gpioStatus = 8'h00;
        // Sleep sampling selection
        chkVal({1'b0, groupSampleEn}, 8'h55);
        sleepState = 1'b1;
        step(2);
        chkVal({1'b0, buttonSampleEn}, 8'h00);
        chkVal({1'b0, groupSampleEn}, 8'h00);
        wr(`TISM_ADDR_SLEEP_SELECT, 8'h85);
        step(1);
        chkVal({1'b0, buttonSampleEn}, 8'h05);
        chkVal({1'b0, groupSampleEn}, 8'h55);
        chkVal(firstConvPending, 8'h85);
        chkVal(i_tism_host_model.recalMask, 8'h85);
        buttonTouchRaw = 7'h02;
        step(2);
        chkVal({1'b0, buttonTouchValid}, 8'h00);
        buttonTouchRaw = 7'h04;
        step(2);
        chkVal({1'b0, buttonTouchValid}, 8'h04);
        buttonTouchRaw = 7'h00;
        conversionDone = 1'b1;
        step(1);
        conversionDone = 1'b0;
        chkVal(firstConvPending, 8'h00);
        wr(`TISM_ADDR_SLEEP_SELECT, 8'h87);
        step(1);
        chkVal(firstConvPending, 8'h02);
        chkVal(i_tism_host_model.recalMask, 8'h02);
        sleepState = 1'b0;
        groupSensorEnable = 7'h7F;
        wr(`TISM_ADDR_SLEEP_SELECT, 8'h00);
        step(2);
        chkVal({1'b0, buttonSampleEn}, 8'h7F);
        // Button limits: accept lowest touches, flag the excess
        for (int b = 0; b < 4; b++) begin
            wr(`TISM_ADDR_MULTI_CONFIG, 8'h80 | 8'(b << 2));
            expMask = 7'((1 << (b + 1)) - 1);
            buttonTouchRaw = 7'h7F;
            step(2);
            chkVal({1'b0, buttonTouchValid}, {1'b0, expMask});
            chkBit(multiFlags.button, 1'b1);
            buttonTouchRaw = expMask;
            step(2);
            chkBit(multiFlags.button, 1'b0);
            buttonTouchRaw = 7'h00;
            step(2);
        end
        // Accepted touch is held until released
        wr(`TISM_ADDR_MULTI_CONFIG, 8'h82);
        buttonTouchRaw = 7'h03;
        step(2);
        chkVal({1'b0, buttonTouchValid}, 8'h01);
        buttonTouchRaw = 7'h07;
        step(2);
        chkVal({1'b0, buttonTouchValid}, 8'h01);
        buttonTouchRaw = 7'h06;
        step(2);
        chkVal({1'b0, buttonTouchValid}, 8'h02);
        buttonTouchRaw = 7'h00;
        // Group limits in their own encoding
        for (int g = 0; g < 4; g++) begin
            wr(`TISM_ADDR_MULTI_CONFIG, 8'h80 | 8'(g));
            expMask = 7'((1 << grpLimit[g]) - 1);
            groupTouchRaw = 7'h7F;
            step(2);
            chkVal({1'b0, groupTouchValid}, {1'b0, expMask});
            chkBit(multiFlags.group, 1'b1);
            groupTouchRaw = expMask;
            step(2);
            chkBit(multiFlags.group, 1'b0);
            groupTouchRaw = 7'h00;
            step(2);
        end
        // Blocking off passes every touch but still flags
        wr(`TISM_ADDR_MULTI_CONFIG, 8'h00);
        buttonTouchRaw = 7'h7F;
        step(2);
        chkVal({1'b0, buttonTouchValid}, 8'h7F);
        chkBit(multiFlags.button, 1'b1);
        buttonTouchRaw = 7'h00;
        summarize();
    end
endmodule // touch_irq_sleep_multitouch_tb
